// ==== include/mcr_pkg.sv ====
// Shared constants, codes and types of the memory command responder.
package mcr_pkg;
  // Command codes received and reply codes sent.
  localparam logic [7:0] CMD_WRITE       = 8'h02;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h03;
  localparam logic [7:0] CMD_READ        = 8'h04;
  localparam logic [7:0] CMD_VERIFY      = 8'h05;
  localparam logic [7:0] CMD_VER_INST    = 8'h06;
  localparam logic [7:0] RSP_READ        = 8'h84;
  localparam logic [7:0] RSP_VERIFY      = 8'h85;
  localparam logic [7:0] RSP_VER_INST    = 8'h86;
  localparam logic [7:0] RSP_FLAG        = 8'h80;
  // Result codes.
  localparam logic [7:0] RES_OK          = 8'h00;
  localparam logic [7:0] RES_GENERAL     = 8'h01;
  localparam logic [7:0] RES_BAD_LEN     = 8'h02;
  localparam logic [7:0] RES_BLK_RANGE   = 8'h03;
  localparam logic [7:0] RES_BLK_CROSS   = 8'h04;
  localparam logic [7:0] RES_FS_MOUNTED  = 8'h05;
  localparam logic [7:0] RES_UNKNOWN     = 8'h06;
  localparam logic [7:0] RES_BUSY        = 8'h07;
  localparam logic [7:0] RES_ERASE_FAIL  = 8'h10;
  localparam logic [7:0] RES_WRITE_FAIL  = 8'h20;
  localparam logic [7:0] RES_FS_HEADER   = 8'h21;
  localparam logic [7:0] RES_RD_FAIL     = 8'h30;
  localparam logic [7:0] RES_RD_TOO_BIG  = 8'h31;
  localparam logic [7:0] RES_NO_BUFFER   = 8'h32;
  localparam logic [7:0] RES_VERIFY_FAIL = 8'h40;
  localparam logic [7:0] RES_INCOMPAT    = 8'h41;
  localparam logic [7:0] RES_CORRUPT     = 8'h42;
  localparam logic [7:0] RES_INST_FAIL   = 8'h50;
  // Register byte addresses.
  localparam logic [3:0] REG_MAX_BLOCK   = 4'h0;
  localparam logic [3:0] REG_BLOCK_SIZE  = 4'h4;
  localparam logic [3:0] REG_LIMITS      = 4'h8;
  localparam logic [3:0] REG_STATUS      = 4'hc;
  // Field positions.
  localparam int LIM_FS_BIT   = 16;
  localparam int STA_BUSY_BIT = 0;
  localparam int STA_PEND_BIT = 1;
  localparam int STA_LAST_LSB = 8;
  localparam int STA_WE_LSB   = 16;
  localparam int STA_ST_LSB   = 24;
  // Reset values.
  localparam logic [15:0] MAX_BLOCK_RST  = 16'h001f;
  localparam logic [15:0] BLOCK_SIZE_RST = 16'h0800;
  localparam logic [8:0]  MAX_PL_RST     = 9'h100;
  // Read buffer.
  localparam int BUF_DEPTH = 256;
  localparam int BUF_AW    = 8;
  // Timing.
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CHECK_TIME_MS   = 500;
  localparam int unsigned INSTALL_TIME_MS = 8000;
  localparam int unsigned CHECK_CYC   = CHECK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned INSTALL_CYC = INSTALL_TIME_MS * (CLK_HZ / 1000);
  localparam int TMR_W = 27;

  typedef enum logic [7:0] {
    ST_IDLE    = 8'h01,
    ST_FETCH   = 8'h02,
    ST_HDR     = 8'h04,
    ST_DATA    = 8'h08,
    ST_CHECK   = 8'h10,
    ST_TXWAIT  = 8'h20,
    ST_INSTALL = 8'h40,
    ST_SPARE   = 8'h80
  } mcr_state_t;
endpackage

// ==== hw/mcr_timer.sv ====
// One-shot cycle timer with a one-cycle expiry pulse.
`timescale 1ns/10ps
module mcr_timer
  import mcr_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             LOAD,
  input  wire logic             CLEAR,
  input  wire logic [TMR_W-1:0] CYCLES,
  output logic                  EXPIRED
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic             run;
    logic             exp;
  } mcr_tmr_t;

  mcr_tmr_t tmr_ff;
  mcr_tmr_t nxt_tmr;

  always_comb begin
    nxt_tmr = tmr_ff;
    nxt_tmr.exp = 1'b0;
    if (CLEAR) begin
      nxt_tmr.run = 1'b0;
    end else if (LOAD) begin
      nxt_tmr.cnt = CYCLES;
      nxt_tmr.run = 1'b1;
    end else if (tmr_ff.run) begin
      if (tmr_ff.cnt <= TMR_W'(1)) begin
        nxt_tmr.run = 1'b0;
        nxt_tmr.exp = 1'b1;
      end else begin
        nxt_tmr.cnt = tmr_ff.cnt - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign EXPIRED = tmr_ff.exp;
endmodule

// ==== hw/mcr_responder.sv ====
// Memory command responder: read, image check and check-and-install replies.
//
// Overview of operation
// - A unicast read request is answered with reply command code 0x84.
// - Every reply carries a result byte; zero is success, nonzero names the cause.
// - Read reply echoes the request's block index and byte offset; nonzero-options and busy refusals carry zeros.
// - Read reply carries fetched bytes; byte count equals bytes returned.
// - Only unicast commands get replies, addressed to the requester's source endpoint.
// - Codes 0x05 and 0x06 start a check of the stored update image.
// - Check-and-install sends its reply first, then installs and resets itself.
// - Radio reception is held off while the image check runs, about half a second.
// - Image-check reply uses code 0x85 with zero block, offset, count, no payload.
// - Check-and-install reply uses code 0x86 with zero unused fields.
// - General failure 0x01, bad payload length 0x02, block beyond highest 0x03.
// - Boundary 0x04, mounted file system 0x05, unknown 0x06, busy 0x07.
// - Failed flash erase reports 0x10, failed flash write reports 0x20.
// - A write leaving a valid file system header is refused with 0x21.
// - Read failure 0x30, oversize read 0x31, no reply buffer 0x32.
// - Check failure 0x40, incompatible image 0x41, corrupted image 0x42.
// - A failed install of a valid image reports 0x50.
// - An invalid image is never installed; the current image keeps running.
// - Install may take eight seconds, silent on all links, then reset.
`timescale 1ns/10ps
module mcr_responder
  import mcr_pkg::*;
#(
  parameter int unsigned CHECK_CYCLES   = CHECK_CYC,
  parameter int unsigned INSTALL_CYCLES = INSTALL_CYC
)(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  input  wire logic        CMD_VALID,
  input  wire logic        CMD_UNICAST,
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic [7:0]  CMD_OPTIONS,
  input  wire logic [15:0] CMD_BLOCK,
  input  wire logic [15:0] CMD_OFFSET,
  input  wire logic [15:0] CMD_COUNT,
  input  wire logic [15:0] CMD_PAYLOAD_LEN,
  input  wire logic [7:0]  CMD_SRC_EP,
  input  wire logic        BUF_AVAIL,
  output logic             FL_RD_REQ,
  output logic      [15:0] FL_RD_BLOCK,
  output logic      [15:0] FL_RD_INDEX,
  input  wire logic        FL_RD_VALID,
  input  wire logic        FL_RD_ERR,
  input  wire logic [7:0]  FL_RD_DATA,
  output logic             CHK_START,
  input  wire logic        CHK_DONE,
  input  wire logic [7:0]  CHK_CODE,
  output logic             RPL_VALID,
  input  wire logic        RPL_READY,
  output logic      [7:0]  RPL_DEST_EP,
  output logic      [7:0]  RPL_CODE,
  output logic      [7:0]  RPL_RESULT,
  output logic      [15:0] RPL_BLOCK,
  output logic      [15:0] RPL_OFFSET,
  output logic      [15:0] RPL_COUNT,
  output logic             RPL_DATA_VALID,
  input  wire logic        RPL_DATA_READY,
  output logic      [7:0]  RPL_DATA,
  input  wire logic        TX_DONE,
  output logic             INST_START,
  input  wire logic        INST_DONE,
  input  wire logic        INST_FAIL,
  output logic             RX_HOLD,
  output logic             QUIET,
  output logic             SELF_RESET,
  input  wire logic        WE_DONE,
  input  wire logic        WE_ERASE_FAIL,
  input  wire logic        WE_WRITE_FAIL,
  input  wire logic        WE_FS_HDR,
  output logic      [7:0]  WE_RESULT
);
  typedef struct packed {
    mcr_state_t  st;
    logic [15:0] max_blk;
    logic [15:0] blk_size;
    logic [8:0]  max_pl;
    logic        fs_mnt;
    logic [31:0] rdata;
    logic        pend_v;
    logic [7:0]  pend_code;
    logic [7:0]  pend_ep;
    logic [7:0]  rdest;
    logic [7:0]  rcode;
    logic [7:0]  rres;
    logic [15:0] rblk;
    logic [15:0] roff;
    logic [15:0] rcnt;
    logic [15:0] idx;
    logic        wait_rd;
    logic        rd_req;
    logic [15:0] fl_index;
    logic [7:0]  data;
    logic        inst_want;
    logic        inst_go;
    logic        chk_start;
    logic        inst_start;
    logic        self_rst;
    logic [7:0]  last_res;
    logic [7:0]  we_res;
  } mcr_regs_t;

  mcr_regs_t s_ff;
  mcr_regs_t nxt_s;
  logic [7:0] buf_mem [BUF_DEPTH];

  logic        cmd_take;
  logic [16:0] rd_end;
  logic [7:0]  rd_res;
  logic        chk_load;
  logic        chk_clear;
  logic        chk_exp;
  logic        inst_load;
  logic        inst_exp;
  logic [15:0] idx_nxt;

  // Broadcast frames are never answered, so they are not taken at all.
  // unicast only
  assign cmd_take = CMD_VALID && CMD_UNICAST;
  assign rd_end   = {1'b0, CMD_OFFSET} + {1'b0, CMD_COUNT};
  assign idx_nxt  = s_ff.idx + 16'h0001;

  // The read checks are ordered so the most basic fault is reported.
  always_comb begin
    rd_res = RES_OK;
    if (s_ff.fs_mnt) begin
      rd_res = RES_FS_MOUNTED;
    end else if (CMD_BLOCK > s_ff.max_blk) begin
      rd_res = RES_BLK_RANGE;
    end else if (CMD_PAYLOAD_LEN != 16'h0000) begin
      rd_res = RES_BAD_LEN;
    end else if (rd_end > {1'b0, s_ff.blk_size}) begin
      rd_res = RES_BLK_CROSS;
    end else if (CMD_COUNT > {7'h00, s_ff.max_pl} || CMD_COUNT > 16'(BUF_DEPTH)) begin
      rd_res = RES_RD_TOO_BIG;
    end else if (!BUF_AVAIL) begin
      rd_res = RES_NO_BUFFER;
    end
  end

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rd_req = 1'b0;
    nxt_s.chk_start = 1'b0;
    nxt_s.inst_start = 1'b0;
    nxt_s.self_rst = 1'b0;
    nxt_s.rdata = 32'h0000_0000;
    chk_load = 1'b0;
    chk_clear = 1'b0;
    inst_load = 1'b0;

    if (REG_WR) begin
      unique case (REG_ADDR)
        REG_MAX_BLOCK: nxt_s.max_blk = REG_WDATA[15:0];
        REG_BLOCK_SIZE: nxt_s.blk_size = REG_WDATA[15:0];
        REG_LIMITS: begin
          nxt_s.max_pl = REG_WDATA[8:0];
          nxt_s.fs_mnt = REG_WDATA[LIM_FS_BIT];
        end
        default: ;
      endcase
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_MAX_BLOCK: nxt_s.rdata = {16'h0000, s_ff.max_blk};
        REG_BLOCK_SIZE: nxt_s.rdata = {16'h0000, s_ff.blk_size};
        REG_LIMITS: begin
          nxt_s.rdata[8:0] = s_ff.max_pl;
          nxt_s.rdata[LIM_FS_BIT] = s_ff.fs_mnt;
        end
        REG_STATUS: begin
          nxt_s.rdata[STA_BUSY_BIT] = (s_ff.st != ST_IDLE);
          nxt_s.rdata[STA_PEND_BIT] = s_ff.pend_v;
          nxt_s.rdata[STA_LAST_LSB +: 8] = s_ff.last_res;
          nxt_s.rdata[STA_WE_LSB +: 8] = s_ff.we_res;
          nxt_s.rdata[STA_ST_LSB +: 8] = s_ff.st;
        end
        default: ;
      endcase
    end

    // Results of the separate write and erase engine are encoded here.
    if (WE_DONE) begin
      if (WE_FS_HDR) begin
        nxt_s.we_res = RES_FS_HEADER;
      end else if (WE_WRITE_FAIL) begin
        nxt_s.we_res = RES_WRITE_FAIL;
      end else if (WE_ERASE_FAIL) begin
        nxt_s.we_res = RES_ERASE_FAIL;
      end else begin
        nxt_s.we_res = RES_OK;
      end
    end

    // One slot remembers a refused command; further ones are dropped.
    // busy refusal
    if (cmd_take && (s_ff.st != ST_IDLE) && !s_ff.pend_v) begin
      nxt_s.pend_v = 1'b1;
      nxt_s.pend_code = CMD_CODE;
      nxt_s.pend_ep = CMD_SRC_EP;
    end

    unique case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.pend_v) begin
          nxt_s.pend_v = 1'b0;
          nxt_s.rdest = s_ff.pend_ep;
          nxt_s.rcode = s_ff.pend_code | RSP_FLAG;
          nxt_s.rres = RES_BUSY;
          nxt_s.rblk = 16'h0000;
          nxt_s.roff = 16'h0000;
          nxt_s.rcnt = 16'h0000;
          nxt_s.st = ST_HDR;
        end else if (cmd_take && CMD_CODE != CMD_WRITE && CMD_CODE != CMD_ERASE_WRITE) begin
          nxt_s.rdest = CMD_SRC_EP;
          nxt_s.rcode = CMD_CODE | RSP_FLAG;
          nxt_s.rblk = 16'h0000;
          nxt_s.roff = 16'h0000;
          nxt_s.rcnt = 16'h0000;
          nxt_s.idx = 16'h0000;
          nxt_s.inst_go = 1'b0;
          nxt_s.st = ST_HDR;
          if (CMD_OPTIONS != 8'h00) begin
            nxt_s.rres = RES_GENERAL;
          end else if (CMD_CODE == CMD_READ) begin
            nxt_s.rcode = RSP_READ;
            nxt_s.rblk = CMD_BLOCK;
            nxt_s.roff = CMD_OFFSET;
            nxt_s.rres = rd_res;
            if (rd_res == RES_OK && CMD_COUNT != 16'h0000) begin
              nxt_s.rcnt = CMD_COUNT;
              nxt_s.wait_rd = 1'b0;
              nxt_s.st = ST_FETCH;
            end
          end else if (CMD_CODE == CMD_VERIFY || CMD_CODE == CMD_VER_INST) begin
            nxt_s.inst_want = (CMD_CODE == CMD_VER_INST);
            nxt_s.chk_start = 1'b1;
            chk_load = 1'b1;
            nxt_s.st = ST_CHECK;
          end else begin
            nxt_s.rres = RES_UNKNOWN;
          end
        end
      end
      ST_FETCH: begin
        if (!s_ff.wait_rd) begin
          nxt_s.rd_req = 1'b1;
          nxt_s.wait_rd = 1'b1;
          nxt_s.fl_index = s_ff.roff + s_ff.idx;
        end else if (FL_RD_ERR) begin
          nxt_s.rres = RES_RD_FAIL;
          nxt_s.rcnt = 16'h0000;
          nxt_s.wait_rd = 1'b0;
          nxt_s.st = ST_HDR;
        end else if (FL_RD_VALID) begin
          nxt_s.wait_rd = 1'b0;
          if (idx_nxt == s_ff.rcnt) begin
            nxt_s.idx = 16'h0000;
            nxt_s.st = ST_HDR;
          end else begin
            nxt_s.idx = idx_nxt;
          end
        end
      end
      ST_HDR: begin
        if (RPL_READY) begin
          nxt_s.last_res = s_ff.rres;
          if (s_ff.rcnt != 16'h0000) begin
            nxt_s.idx = 16'h0000;
            nxt_s.data = buf_mem[0];
            nxt_s.st = ST_DATA;
          end else if (s_ff.inst_go) begin
            nxt_s.st = ST_TXWAIT;
          end else begin
            nxt_s.st = ST_IDLE;
          end
        end
      end
      ST_DATA: begin
        if (RPL_DATA_READY) begin
          if (idx_nxt == s_ff.rcnt) begin
            nxt_s.st = ST_IDLE;
          end else begin
            nxt_s.idx = idx_nxt;
            nxt_s.data = buf_mem[idx_nxt[BUF_AW-1:0]];
          end
        end
      end
      ST_CHECK: begin
        if (CHK_DONE) begin
          chk_clear = 1'b1;
          nxt_s.rres = CHK_CODE;
          nxt_s.inst_go = s_ff.inst_want && (CHK_CODE == RES_OK);
          nxt_s.st = ST_HDR;
        end else if (chk_exp) begin
          nxt_s.rres = RES_VERIFY_FAIL;
          nxt_s.inst_go = 1'b0;
          nxt_s.st = ST_HDR;
        end
      end
      ST_TXWAIT: begin
        if (TX_DONE) begin
          nxt_s.inst_go = 1'b0;
          nxt_s.inst_start = 1'b1;
          inst_load = 1'b1;
          nxt_s.st = ST_INSTALL;
        end
      end
      ST_INSTALL: begin
        if (INST_DONE) begin
          nxt_s.self_rst = 1'b1;
          nxt_s.st = ST_IDLE;
        end else if (INST_FAIL || inst_exp) begin
          nxt_s.rcode = RSP_VER_INST;
          nxt_s.rres = RES_INST_FAIL;
          nxt_s.st = ST_HDR;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      s_ff <= '0;
      s_ff.st <= ST_IDLE;
      s_ff.max_blk <= MAX_BLOCK_RST;
      s_ff.blk_size <= BLOCK_SIZE_RST;
      s_ff.max_pl <= MAX_PL_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // The buffer lets a failed fetch still be answered with a clean error reply.
  // payload capture
  always_ff @(posedge CLOCK) begin
    if (s_ff.st == ST_FETCH && s_ff.wait_rd && FL_RD_VALID && !FL_RD_ERR) begin
      buf_mem[s_ff.idx[BUF_AW-1:0]] <= FL_RD_DATA;
    end
  end

  mcr_timer u_chk_tmr (
    .CLK     (CLOCK),
    .RST     (RST),
    .LOAD    (chk_load),
    .CLEAR   (chk_clear),
    .CYCLES  (TMR_W'(CHECK_CYCLES)),
    .EXPIRED (chk_exp)
  );

  mcr_timer u_inst_tmr (
    .CLK     (CLOCK),
    .RST     (RST),
    .LOAD    (inst_load),
    .CLEAR   (1'b0),
    .CYCLES  (TMR_W'(INSTALL_CYCLES)),
    .EXPIRED (inst_exp)
  );

  assign REG_RDATA      = s_ff.rdata;
  assign FL_RD_REQ      = s_ff.rd_req;
  assign FL_RD_BLOCK    = s_ff.rblk;
  assign FL_RD_INDEX    = s_ff.fl_index;
  assign CHK_START      = s_ff.chk_start;
  assign RPL_VALID      = (s_ff.st == ST_HDR);
  assign RPL_DEST_EP    = s_ff.rdest;
  assign RPL_CODE       = s_ff.rcode;
  assign RPL_RESULT     = s_ff.rres;
  assign RPL_BLOCK      = s_ff.rblk;
  assign RPL_OFFSET     = s_ff.roff;
  assign RPL_COUNT      = s_ff.rcnt;
  assign RPL_DATA_VALID = (s_ff.st == ST_DATA);
  assign RPL_DATA       = s_ff.data;
  assign INST_START     = s_ff.inst_start;
  assign RX_HOLD        = (s_ff.st == ST_CHECK);
  assign QUIET          = (s_ff.st == ST_INSTALL);
  assign SELF_RESET     = s_ff.self_rst;
  assign WE_RESULT      = s_ff.we_res;
endmodule

// ==== sim/mcr_responder_props.sv ====
// Port checks of the memory command responder.
`timescale 1ns/10ps
module mcr_responder_props
  import mcr_pkg::*;
(
  input wire logic       CLOCK,
  input wire logic       RST,
  input wire logic       CHK_START,
  input wire logic       CHK_DONE,
  input wire logic [7:0] CHK_CODE,
  input wire logic       RX_HOLD,
  input wire logic       RPL_VALID,
  input wire logic       RPL_READY,
  input wire logic [7:0] RPL_DEST_EP,
  input wire logic [7:0] RPL_CODE,
  input wire logic [7:0] RPL_RESULT,
  input wire logic [15:0] RPL_BLOCK,
  input wire logic [15:0] RPL_OFFSET,
  input wire logic [15:0] RPL_COUNT,
  input wire logic       TX_DONE,
  input wire logic       INST_START,
  input wire logic       INST_DONE,
  input wire logic       QUIET,
  input wire logic       SELF_RESET
);
  logic chk_ok_ff;

  // Remembers whether the latest check found a good image.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) chk_ok_ff <= 1'b0;
    else if (CHK_START) chk_ok_ff <= 1'b0;
    else if (CHK_DONE) chk_ok_ff <= (CHK_CODE == RES_OK);
  end

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  AST_CHK_HOLD: assert property (CHK_START |-> RX_HOLD)
    else $error("No radio hold in check.");
  AST_CHK_RESULT: assert property (CHK_DONE && RX_HOLD |=> RPL_VALID && RPL_RESULT == $past(CHK_CODE))
    else $error("Check result lost.");
  AST_IMG_ZERO: assert property (RPL_VALID && (RPL_CODE == RSP_VERIFY || RPL_CODE == RSP_VER_INST)
    |-> RPL_BLOCK == 16'h0 && RPL_OFFSET == 16'h0 && RPL_COUNT == 16'h0)
    else $error("Image reply field nonzero.");
  AST_RD_FAIL_CNT: assert property (RPL_VALID && RPL_CODE == RSP_READ && RPL_RESULT != RES_OK
    |-> RPL_COUNT == 16'h0)
    else $error("Failed read has a count.");
  AST_HDR_HOLD: assert property (RPL_VALID && !RPL_READY |=> RPL_VALID
    && $stable({RPL_CODE, RPL_RESULT, RPL_COUNT, RPL_DEST_EP}))
    else $error("Reply header moved.");
  AST_INST_AFTER_TX: assert property (INST_START |-> $past(TX_DONE))
    else $error("Install before reply left.");
  AST_NO_BAD_INST: assert property (INST_START |-> chk_ok_ff)
    else $error("Install of bad image.");
  AST_QUIET_SILENT: assert property (QUIET |-> !RPL_VALID && !RX_HOLD)
    else $error("Activity while installing.");
  AST_SELF_RST: assert property (SELF_RESET |-> $past(INST_DONE) && !RPL_VALID)
    else $error("Self reset too early.");
endmodule

bind mcr_responder mcr_responder_props i_props (.*);

// ==== sim/mcr_store_model.sv ====
// Model of the flash store, image checker and installer.
`timescale 1ns/10ps
module mcr_store_model
  import mcr_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        FL_RD_REQ,
  input  wire logic [15:0] FL_RD_BLOCK,
  input  wire logic [15:0] FL_RD_INDEX,
  input  wire logic        CHK_START,
  input  wire logic        INST_START,
  input  wire logic        slow,
  input  wire logic        rd_err,
  input  wire logic        chk_hang,
  input  wire logic        inst_bad,
  input  wire logic [7:0]  chk_res,
  output logic             FL_RD_VALID,
  output logic             FL_RD_ERR,
  output logic      [7:0]  FL_RD_DATA,
  output logic             CHK_DONE,
  output logic      [7:0]  CHK_CODE,
  output logic             INST_DONE,
  output logic             INST_FAIL
);
  logic [1:0]  rd_cnt;
  logic [3:0]  chk_cnt, inst_cnt;
  logic [15:0] blk, idx;

  // Idle data lines toggle so stale values never pass as fresh.
  always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      {FL_RD_VALID, FL_RD_ERR, CHK_DONE, INST_DONE, INST_FAIL} <= 5'h0;
      {FL_RD_DATA, CHK_CODE, rd_cnt, chk_cnt, inst_cnt, blk, idx} <= '0;
    end else begin
      {FL_RD_VALID, FL_RD_ERR, CHK_DONE, INST_DONE, INST_FAIL} <= 5'h0;
      FL_RD_DATA <= ~FL_RD_DATA;
      CHK_CODE <= ~CHK_CODE;
      if (FL_RD_REQ) begin
        rd_cnt <= slow ? 2'h3 : 2'h1;
        blk <= FL_RD_BLOCK;
        idx <= FL_RD_INDEX;
      end else if (rd_cnt != 2'h0) begin
        rd_cnt <= rd_cnt - 2'h1;
      end
      if (rd_cnt == 2'h1 && !FL_RD_REQ) begin
        FL_RD_VALID <= !rd_err;
        FL_RD_ERR <= rd_err;
        FL_RD_DATA <= blk[7:0] ^ idx[7:0] ^ 8'ha5;
      end
      if (CHK_START) chk_cnt <= chk_hang ? 4'h0 : 4'h6;
      else if (chk_cnt != 4'h0) chk_cnt <= chk_cnt - 4'h1;
      if (chk_cnt == 4'h1) begin
        CHK_DONE <= 1'b1;
        CHK_CODE <= chk_res;
      end
      if (INST_START) inst_cnt <= 4'h8;
      else if (inst_cnt != 4'h0) inst_cnt <= inst_cnt - 4'h1;
      if (inst_cnt == 4'h1) begin
        INST_DONE <= !inst_bad;
        INST_FAIL <= inst_bad;
      end
    end
  end
endmodule

// ==== sim/mcr_responder_tb.sv ====
// Self-checking bench of the responder.
`timescale 1ns/10ps
module mcr_responder_tb;
  import mcr_pkg::*;
  typedef struct packed {logic [7:0] ep, code, res; logic [15:0] blk, off, cnt;} mcr_rpl_t;
  logic        CLOCK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, CMD_VALID = 1'b0;
  logic        CMD_UNICAST = 1'b0, BUF_AVAIL = 1'b1, RPL_READY = 1'b0, RPL_DATA_READY = 1'b0;
  logic        TX_DONE = 1'b0, WE_DONE = 1'b0, WE_ERASE_FAIL = 1'b0, WE_WRITE_FAIL = 1'b0;
  logic        WE_FS_HDR = 1'b0, slow = 1'b0, rd_err = 1'b0, chk_hang = 1'b0, inst_bad = 1'b0;
  logic [3:0]  REG_ADDR = 4'h0;
  logic [31:0] REG_WDATA = '0, REG_RDATA;
  logic [7:0]  CMD_CODE = '0, CMD_OPTIONS = '0, CMD_SRC_EP = '0, chk_res = '0, ep = '0;
  logic [15:0] CMD_BLOCK = '0, CMD_OFFSET = '0, CMD_COUNT = '0, CMD_PAYLOAD_LEN = '0;
  logic        FL_RD_REQ, FL_RD_VALID, FL_RD_ERR, CHK_START, CHK_DONE, RPL_VALID;
  logic        RPL_DATA_VALID, INST_START, INST_DONE, INST_FAIL, RX_HOLD, QUIET, SELF_RESET;
  logic [15:0] FL_RD_BLOCK, FL_RD_INDEX, RPL_BLOCK, RPL_OFFSET, RPL_COUNT, b, f, n, left, pos;
  logic [7:0]  FL_RD_DATA, CHK_CODE, RPL_DEST_EP, RPL_CODE, RPL_RESULT, RPL_DATA, WE_RESULT;
  integer      seed = 12, fails = 0, samples_checked = 0, cyc = 0, sr_cnt = 0, i;
  mcr_rpl_t    exp_q[$], cur;
  logic [7:0]  e_opt [6] = '{8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0};
  logic [15:0] e_blk [6] = '{16'h0, 16'h20, 16'h0, 16'h0, 16'h0, 16'h0};
  logic [15:0] e_off [6] = '{16'h0, 16'h0, 16'h0, 16'h7fe, 16'h0, 16'h0};
  logic [15:0] e_cnt [6] = '{16'h1, 16'h1, 16'h1, 16'h4, 16'h101, 16'h1};
  logic [7:0]  e_res [6] = '{RES_GENERAL, RES_BLK_RANGE, RES_BAD_LEN, RES_BLK_CROSS,
                             RES_RD_TOO_BIG, RES_NO_BUFFER};
  logic [7:0]  v_res [4] = '{RES_OK, RES_INCOMPAT, RES_CORRUPT, RES_VERIFY_FAIL};

  mcr_responder #(.CHECK_CYCLES(50), .INSTALL_CYCLES(100)) i_dut (.*);
  mcr_store_model i_store (.*);

  always #50 CLOCK = ~CLOCK;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic reg_io(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    if (w) REG_WR <= 1'b1;
    else REG_RD <= 1'b1;
    @(posedge CLOCK);
    {REG_WR, REG_RD} <= 2'b00;
    #1 if (!w) chk(REG_RDATA, d);
  endtask

  task automatic cmd(input logic [7:0] c, o = 0, input logic [15:0] bk = 0, of = 0, ct = 0,
                     pl = 0, input logic u = 1);
    ep = 8'($random(seed));
    @(posedge CLOCK);
    {CMD_VALID, CMD_UNICAST, CMD_CODE, CMD_OPTIONS, CMD_SRC_EP} <= {1'b1, u, c, o, ep};
    {CMD_BLOCK, CMD_OFFSET, CMD_COUNT, CMD_PAYLOAD_LEN} <= {bk, of, ct, pl};
    @(posedge CLOCK);
    CMD_VALID <= 1'b0;
  endtask

  task automatic expect_rpl(input logic [7:0] c, r, input logic [15:0] bk = 0, of = 0, ct = 0);
    exp_q.push_back({ep, c, r, bk, of, ct});
  endtask

  task automatic settle;
    while (exp_q.size() != 0) @(posedge CLOCK);
    repeat (60) @(posedge CLOCK);
  endtask

  // Reply sink with random stalls; also cuts a hang short.
  always @(posedge CLOCK) begin
    TX_DONE <= 1'b0;
    if (RPL_VALID && RPL_READY) begin
      chk(left, 32'h0);
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else begin
        cur = exp_q.pop_front();
        chk(RPL_DEST_EP, cur.ep);
        chk(RPL_CODE, cur.code);
        chk(RPL_RESULT, cur.res);
        chk({RPL_BLOCK, RPL_OFFSET}, {cur.blk, cur.off});
        chk(RPL_COUNT, cur.cnt);
        left = cur.cnt;
        pos = cur.off;
        TX_DONE <= (cur.code == RSP_VER_INST) && (cur.res == RES_OK);
      end
    end
    if (RPL_DATA_VALID && RPL_DATA_READY) begin
      chk(left != 16'h0, 32'h1);
      chk(RPL_DATA, cur.blk[7:0] ^ pos[7:0] ^ 8'ha5);
      left = left - 16'h1;
      pos = pos + 16'h1;
    end
    if (SELF_RESET) sr_cnt++;
    RPL_READY <= 1'($random(seed));
    RPL_DATA_READY <= 1'($random(seed));
    cyc++;
    if (cyc == 40000) begin
      fails++;
      final_report;
    end
  end

  initial begin
    left = '0;
    repeat (5) @(posedge CLOCK);
    RST <= 1'b0;
    reg_io(0, REG_MAX_BLOCK, 32'h1f);
    reg_io(0, REG_BLOCK_SIZE, 32'h800);
    reg_io(0, REG_LIMITS, 32'h100);
    reg_io(0, 4'h2, 32'h0);
    reg_io(0, REG_STATUS, 32'h01000000);
    for (i = 0; i < 6; i++) begin
      b = 16'($random(seed)) & 16'h1f;
      n = 16'h1 + (16'($random(seed)) & 16'hf);
      f = 16'($random(seed)) & 16'h7ff;
      if (i == 0 || f + n > 16'h800) f = 16'h800 - n;
      slow <= i[0];
      cmd(CMD_READ, 0, b, f, n);
      expect_rpl(RSP_READ, RES_OK, b, f, n);
      settle;
    end
    for (i = 0; i < 6; i++) begin
      BUF_AVAIL <= (i != 5);
      cmd(CMD_READ, e_opt[i], e_blk[i], e_off[i], e_cnt[i], (i == 2) ? 16'h1 : 16'h0, 1'b1);
      expect_rpl(RSP_READ, e_res[i], e_blk[i], e_off[i]);
      settle;
    end
    BUF_AVAIL <= 1'b1;
    reg_io(1, REG_LIMITS, 32'h10100);
    cmd(CMD_READ, 0, 16'h1, 16'h0, 16'h2);
    expect_rpl(RSP_READ, RES_FS_MOUNTED, 16'h1);
    settle;
    reg_io(1, REG_LIMITS, 32'h100);
    rd_err <= 1'b1;
    cmd(CMD_READ, 0, 16'h2, 16'h0, 16'h3);
    expect_rpl(RSP_READ, RES_RD_FAIL, 16'h2);
    settle;
    rd_err <= 1'b0;
    cmd(8'h07);
    expect_rpl(8'h87, RES_UNKNOWN);
    cmd(CMD_READ, 0, 16'h1, 16'h0, 16'h2, 0, 0);
    settle;
    // A command during a slow read takes the single busy slot; a third is dropped.
    slow <= 1'b1;
    cmd(CMD_READ, 0, 16'h3, 16'h10, 16'h8);
    expect_rpl(RSP_READ, RES_OK, 16'h3, 16'h10, 16'h8);
    cmd(CMD_VERIFY);
    expect_rpl(RSP_VERIFY, RES_BUSY);
    cmd(CMD_READ, 0, 16'h1, 16'h0, 16'h1);
    settle;
    for (i = 0; i < 4; i++) begin
      chk_res <= v_res[i];
      cmd(CMD_VERIFY);
      expect_rpl(RSP_VERIFY, v_res[i]);
      settle;
    end
    chk_res <= RES_CORRUPT;
    cmd(CMD_VER_INST);
    expect_rpl(RSP_VER_INST, RES_CORRUPT);
    settle;
    chk_hang <= 1'b1;
    cmd(CMD_VERIFY);
    expect_rpl(RSP_VERIFY, RES_VERIFY_FAIL);
    settle;
    {chk_hang, inst_bad, chk_res} <= {2'b01, RES_OK};
    cmd(CMD_VER_INST);
    expect_rpl(RSP_VER_INST, RES_OK);
    expect_rpl(RSP_VER_INST, RES_INST_FAIL);
    settle;
    for (i = 0; i < 8; i++) begin
      @(posedge CLOCK);
      {WE_DONE, WE_FS_HDR, WE_WRITE_FAIL, WE_ERASE_FAIL} <= {1'b1, i[2:0]};
      @(posedge CLOCK);
      WE_DONE <= 1'b0;
      @(posedge CLOCK);
      #1 chk(WE_RESULT, i[2] ? RES_FS_HEADER : i[1] ? RES_WRITE_FAIL :
             i[0] ? RES_ERASE_FAIL : RES_OK);
    end
    reg_io(0, REG_STATUS, {ST_IDLE, RES_FS_HEADER, RES_INST_FAIL, 8'h0});
    inst_bad <= 1'b0;
    cmd(CMD_VER_INST);
    expect_rpl(RSP_VER_INST, RES_OK);
    settle;
    chk(sr_cnt, 32'h1);
    // The self reset is acted on by a real reset in mid-run.
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    reg_io(0, REG_STATUS, 32'h01000000);
    final_report;
  end
endmodule
